// ### common/sfc_core_if.sv
// Purpose: Carrier between the command engine, status and array blocks
// Assumes: All signals on i_core_clk
// Notes:   Command strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface sfc_core_if;
  import sfc_pkg::*;

  logic       set_wel;
  logic       clr_wel;
  logic       set_vol;
  logic       wsr_go;
  logic       wsr_vol;
  logic [7:0] wsr_data;
  logic       op_done;
  logic       ext_busy;
  logic [7:0] status;
  logic       busy;
  logic       vol_en;
  sfc_idx_t   rd_idx;
  logic [7:0] rd_data;
  logic       ld_we;
  sfc_idx_t   ld_idx;
  logic [7:0] ld_data;

  modport eng  (output set_wel, clr_wel, set_vol, wsr_go, wsr_vol, wsr_data,
                output op_done, ext_busy, rd_idx, ld_we, ld_idx, ld_data,
                input  status, busy, vol_en, rd_data);
  modport stat (input  set_wel, clr_wel, set_vol, wsr_go, wsr_vol, wsr_data,
                input  op_done, ext_busy,
                output status, busy, vol_en);
  modport mem  (input  rd_idx, ld_we, ld_idx, ld_data,
                output rd_data);
endinterface : sfc_core_if
`default_nettype wire

// ### common/sfc_pkg.sv
// Purpose: Types shared by the serial flash command slice
// Assumes: Array is a small flip-flop store indexed by low address bits
// Notes:   Constants live in sfc_regs.svh
package sfc_pkg;

  localparam int MEM_AW = 8;

  typedef logic [MEM_AW-1:0] sfc_idx_t;

  typedef enum logic [2:0] {
    SFC_IDLE,
    SFC_OPC,
    SFC_HOLD,
    SFC_ADDR,
    SFC_DUMMY,
    SFC_OUT,
    SFC_WSR,
    SFC_SKIP
  } sfc_state_t;

  // Array index from a 24-bit byte address
  function automatic sfc_idx_t sfc_index(input logic [23:0] addr);
    sfc_index = addr[MEM_AW-1:0];
  endfunction : sfc_index

endpackage : sfc_pkg

// ### common/sfc_regs.svh
// Purpose: Constants for the serial flash command slice
// Assumes: 125 MHz core clock, one status byte, 32-bit register port
// Notes:   Offsets are byte addresses on the plain register port
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// Opcodes
`define SFC_OP_WREN     8'h06
`define SFC_OP_VWREN    8'h50
`define SFC_OP_WRDI     8'h04
`define SFC_OP_RDSR     8'h05
`define SFC_OP_WRSR     8'h01
`define SFC_OP_READ     8'h03
`define SFC_OP_FAST     8'h0B
`define SFC_OP_DUAL     8'h3B

// Status byte fields
`define SFC_ST_BUSY     0
`define SFC_ST_WLATCH   1
`define SFC_ST_GSIZE_LO 2
`define SFC_ST_GSIZE_HI 3
`define SFC_ST_GBOTTOM  5
`define SFC_ST_LOCK     7
`define SFC_ST_WMASK    8'hAC
`define SFC_ST_RESET    8'h00

// Register port offsets and control register bits
`define SFC_REG_STATUS  8'h00
`define SFC_REG_CTRL    8'h04
`define SFC_REG_MADDR   8'h08
`define SFC_REG_MDATA   8'h0C
`define SFC_CTRL_XBUSY  0
`define SFC_CTRL_DONE   1

// Timing
`define SFC_CLK_NS      8
`define SFC_TW_NS       10000000

`endif

// ### rtl/sfc_array.sv
// Purpose: Flip-flop data array read by the stream engine
// Assumes: Loaded from the register port
// Notes:   Address bits above the index alias
`timescale 1ns/10ps
`default_nettype none
module sfc_array (
  input  wire logic i_core_clk,
  sfc_core_if.mem   cif
);
  import sfc_pkg::*;

  logic [7:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge i_core_clk) begin
    if (cif.ld_we) begin
      mem[cif.ld_idx] <= cif.ld_data;
    end
  end

  assign cif.rd_data = mem[cif.rd_idx];
endmodule : sfc_array
`default_nettype wire

// ### rtl/sfc_status.sv
// Purpose: Status byte, write latch, volatile enable and write timer
// Assumes: Command strobes arrive as single-cycle pulses
// Notes:   Busy also follows the external busy level
`timescale 1ns/10ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_status #(
  parameter int unsigned TW_CYC = 1
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  sfc_core_if.stat  cif
);
  import sfc_pkg::*;

  logic [7:0]  bits;
  logic [7:0]  pend;
  logic        write_latch_flag;
  logic        vol;
  logic [23:0] timer;
  logic        timer_end;

  assign timer_end = (timer == 24'h000001);

  // Write latch
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      write_latch_flag <= 1'b0;
    end else if (cif.set_wel) begin
      write_latch_flag <= 1'b1;
    end else if (cif.clr_wel) begin
      write_latch_flag <= 1'b0;
    end else if (cif.op_done || timer_end) begin
      write_latch_flag <= 1'b0;
    end
  end

  // Volatile status-write enable
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      vol <= 1'b0;
    end else if (cif.set_vol) begin
      vol <= 1'b1;
    end else if (cif.clr_wel || cif.wsr_go) begin
      vol <= 1'b0;
    end
  end

  // Self-timed non-volatile write cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      timer <= 24'h000000;
    end else if (cif.wsr_go && !cif.wsr_vol) begin
      timer <= 24'(TW_CYC);
    end else if (timer != 24'h000000) begin
      timer <= timer - 24'h000001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend <= `SFC_ST_RESET;
    end else if (cif.wsr_go) begin
      pend <= cif.wsr_data;
    end
  end

  // Writable bits only
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      bits <= `SFC_ST_RESET;
    end else if (cif.wsr_go && cif.wsr_vol) begin
      bits <= cif.wsr_data & `SFC_ST_WMASK;
    end else if (timer_end) begin
      bits <= pend & `SFC_ST_WMASK;
    end
  end

  assign cif.busy   = (timer != 24'h000000) || cif.ext_busy;
  assign cif.vol_en = vol;
  assign cif.status = bits | {6'h00, write_latch_flag, cif.busy};
endmodule : sfc_status
`default_nettype wire

// ### rtl/sfc_top.sv
// Purpose: Serial flash instruction decoder with status and read paths
// Assumes: SPI pins are synchronous to i_core_clk and slower than it
// Notes:   Serial clock edges are found by comparing with last sample
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_top #(
  parameter int unsigned TW_CYC = `SFC_TW_NS / `SFC_CLK_NS
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Serial link
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_lane0,
  input  wire logic        i_lane1,
  output logic             o_lane0,
  output logic             o_lane0_oe,
  output logic             o_lane1,
  output logic             o_lane1_oe,
  input  wire logic        i_write_guard_n,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata
);
  import sfc_pkg::*;

  sfc_core_if cif ();

  sfc_status #(
    .TW_CYC (TW_CYC)
  ) u_status (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .cif        (cif.stat)
  );

  sfc_array u_array (
    .i_core_clk (i_core_clk),
    .cif        (cif.mem)
  );

  sfc_state_t  state;
  logic        sck_q;
  logic        cs_q;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic [4:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic        fast;
  logic        dual;
  logic        from_mem;
  logic        wsr_vol;
  logic [7:0]  out_byte;
  logic [2:0]  out_cnt;
  logic [2:0]  step;
  logic [7:0]  cur;
  logic        byte_end;
  logic        wsr_allowed;
  logic        xbusy;
  sfc_idx_t    ld_idx;

  // Edge detection of synchronous pins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= i_spi_sck;
      cs_q  <= i_spi_cs_n;
    end
  end

  assign sck_rise   = i_spi_sck && !sck_q && !i_spi_cs_n;
  assign sck_fall   = !i_spi_sck && sck_q && !i_spi_cs_n;
  assign cs_fall    = !i_spi_cs_n && cs_q;
  assign cs_rise    = i_spi_cs_n && !cs_q;
  assign next_shreg = {shreg[6:0], i_lane0};
  assign wsr_allowed = (cif.status[`SFC_ST_WLATCH] || cif.vol_en) &&
                       !(cif.status[`SFC_ST_LOCK] && !i_write_guard_n);

  // Output byte: fresh source at each byte start
  assign step     = dual ? 3'd2 : 3'd1;
  assign byte_end = (out_cnt == 3'(8 - step));
  assign cur      = (out_cnt != 3'd0) ? out_byte :
                    from_mem ? cif.rd_data : cif.status;

  // Instruction sequencer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= SFC_IDLE;
    end else if (cs_rise || (i_spi_cs_n && !cs_fall)) begin
      state <= SFC_IDLE;
    end else if (cs_fall) begin
      state <= SFC_OPC;
    end else if (sck_rise) begin
      unique case (state)
        SFC_OPC: begin
          if (bit_cnt == 5'd7) begin
            if (cif.busy && next_shreg != `SFC_OP_RDSR) begin
              state <= SFC_SKIP;
            end else begin
              case (next_shreg)
                `SFC_OP_WREN,
                `SFC_OP_WRDI,
                `SFC_OP_VWREN: state <= SFC_HOLD;
                `SFC_OP_RDSR:  state <= SFC_OUT;
                `SFC_OP_WRSR: begin
                  if (wsr_allowed) begin
                    state <= SFC_WSR;
                  end else begin
                    state <= SFC_SKIP;
                  end
                end
                `SFC_OP_READ,
                `SFC_OP_FAST,
                `SFC_OP_DUAL:  state <= SFC_ADDR;
                default:       state <= SFC_SKIP;
              endcase
            end
          end
        end
        SFC_HOLD: state <= SFC_SKIP;
        SFC_ADDR: begin
          if (bit_cnt == 5'd23) begin
            state <= fast ? SFC_DUMMY : SFC_OUT;
          end
        end
        SFC_DUMMY: begin
          if (bit_cnt == 5'd7) begin
            state <= SFC_OUT;
          end
        end
        SFC_IDLE,
        SFC_OUT,
        SFC_WSR,
        SFC_SKIP: state <= state;
      endcase
    end
  end

  // Bit counter per phase
  always_ff @(posedge i_core_clk) begin
    if (i_rst || cs_fall) begin
      bit_cnt <= 5'd0;
    end else if (sck_rise) begin
      if ((state == SFC_OPC && bit_cnt == 5'd7) ||
          (state == SFC_ADDR && bit_cnt == 5'd23)) begin
        bit_cnt <= 5'd0;
      end else if (bit_cnt != 5'd31) begin
        bit_cnt <= bit_cnt + 5'd1;
      end
    end
  end

  // Input shifter and latched opcode
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      shreg  <= 8'h00;
      opcode <= 8'h00;
    end else if (sck_rise) begin
      shreg <= next_shreg;
      if (state == SFC_OPC && bit_cnt == 5'd7) begin
        opcode <= next_shreg;
      end
    end
  end

  // Read mode flags
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fast     <= 1'b0;
      dual     <= 1'b0;
      from_mem <= 1'b0;
    end else if (sck_rise && state == SFC_OPC && bit_cnt == 5'd7) begin
      fast     <= next_shreg != `SFC_OP_READ;
      dual     <= next_shreg == `SFC_OP_DUAL;
      from_mem <= next_shreg != `SFC_OP_RDSR;
    end
  end

  // Address shift in, then increment per byte
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      addr <= 24'h000000;
    end else if (sck_rise && state == SFC_ADDR) begin
      addr <= {addr[22:0], i_lane0};
    end else if (sck_fall && state == SFC_OUT && from_mem && byte_end) begin
      addr <= addr + 24'h000001;
    end
  end

  // Output shifter on falling edges
  always_ff @(posedge i_core_clk) begin
    if (i_rst || cs_fall) begin
      out_byte <= 8'h00;
      out_cnt  <= 3'd0;
    end else if (sck_fall && state == SFC_OUT) begin
      if (dual) begin
        out_byte <= {cur[5:0], 2'b00};
      end else begin
        out_byte <= {cur[6:0], 1'b0};
      end
      out_cnt <= byte_end ? 3'd0 : out_cnt + step;
    end
  end

  // Output lanes
  always_ff @(posedge i_core_clk) begin
    if (i_rst || cs_rise || i_spi_cs_n) begin
      o_lane0    <= 1'b0;
      o_lane1    <= 1'b0;
      o_lane0_oe <= 1'b0;
      o_lane1_oe <= 1'b0;
    end else if (sck_fall && state == SFC_OUT) begin
      o_lane1    <= cur[7];
      o_lane0    <= dual ? cur[6] : 1'b0;
      o_lane1_oe <= 1'b1;
      o_lane0_oe <= dual;
    end
  end

  // Single-byte commands execute on select rising
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cif.set_wel <= 1'b0;
      cif.clr_wel <= 1'b0;
      cif.set_vol <= 1'b0;
    end else begin
      cif.set_wel <= cs_rise && state == SFC_HOLD &&
                     opcode == `SFC_OP_WREN;
      cif.clr_wel <= cs_rise && state == SFC_HOLD &&
                     opcode == `SFC_OP_WRDI;
      cif.set_vol <= cs_rise && state == SFC_HOLD &&
                     opcode == `SFC_OP_VWREN;
    end
  end

  // Status write: exactly one byte before select rises
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wsr_vol <= 1'b0;
    end else if (sck_rise && state == SFC_OPC && bit_cnt == 5'd7) begin
      wsr_vol <= cif.vol_en;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cif.wsr_go   <= 1'b0;
      cif.wsr_vol  <= 1'b0;
      cif.wsr_data <= 8'h00;
    end else begin
      cif.wsr_go   <= cs_rise && state == SFC_WSR &&
                      bit_cnt == 5'd8;
      cif.wsr_vol  <= wsr_vol;
      cif.wsr_data <= shreg;
    end
  end

  // Register port writes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      xbusy        <= 1'b0;
      cif.op_done  <= 1'b0;
    end else begin
      cif.op_done <= i_reg_wr && i_reg_addr == `SFC_REG_CTRL &&
                     i_reg_wdata[`SFC_CTRL_DONE];
      if (i_reg_wr && i_reg_addr == `SFC_REG_CTRL) begin
        xbusy <= i_reg_wdata[`SFC_CTRL_XBUSY];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ld_idx <= '0;
    end else if (i_reg_wr && i_reg_addr == `SFC_REG_MADDR) begin
      ld_idx <= i_reg_wdata[MEM_AW-1:0];
    end else if (i_reg_wr && i_reg_addr == `SFC_REG_MDATA) begin
      ld_idx <= ld_idx + 8'h01;
    end
  end

  assign cif.ext_busy = xbusy;
  assign cif.rd_idx   = sfc_index(addr);
  assign cif.ld_we    = i_reg_wr && i_reg_addr == `SFC_REG_MDATA;
  assign cif.ld_idx   = ld_idx;
  assign cif.ld_data  = i_reg_wdata[7:0];

  // Register port reads, one cycle later
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_reg_rd) begin
      o_reg_rdata <= 32'h00000000;
    end else begin
      case (i_reg_addr)
        `SFC_REG_STATUS: o_reg_rdata <= {24'h000000, cif.status};
        `SFC_REG_CTRL:   o_reg_rdata <= {31'h00000000, xbusy};
        `SFC_REG_MADDR:  o_reg_rdata <= 32'(ld_idx);
        default:         o_reg_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule : sfc_top
`default_nettype wire

// ### sim/sfc_properties.sv
// Purpose: Port-level checks of the serial flash command slice
// Assumes: Bound to sfc_top
// Notes:   Mirrors the external busy level from register writes
`timescale 1ns/10ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_properties (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Serial link
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_cs_n,
  input  wire logic        o_lane0,
  input  wire logic        o_lane0_oe,
  input  wire logic        o_lane1,
  input  wire logic        o_lane1_oe,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [31:0] o_reg_rdata
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic       sck_q;
  logic       xbusy;
  logic [5:0] rises;
  always_ff @(posedge i_core_clk) begin
    sck_q <= i_spi_sck;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_spi_cs_n) begin
      rises <= 6'h00;
    end else if (i_spi_sck && !sck_q && rises != 6'h3F) begin
      rises <= rises + 6'h01;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      xbusy <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == `SFC_REG_CTRL) begin
      xbusy <= i_reg_wdata[`SFC_CTRL_XBUSY];
    end
  end
  property p_idle_off;
    i_spi_cs_n && $past(i_spi_cs_n) && $past(i_spi_cs_n, 2)
      |-> !o_lane1_oe && !o_lane0_oe;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("output driven idle");
  property p_l1_fall;
    o_lane1_oe && $past(o_lane1_oe) && $changed(o_lane1) |-> !i_spi_sck;
  endproperty
  a_l1_fall: assert property (p_l1_fall) else $error("lane1 changed high");
  property p_l0_fall;
    o_lane0_oe && $past(o_lane0_oe) && $changed(o_lane0) |-> !i_spi_sck;
  endproperty
  a_l0_fall: assert property (p_l0_fall) else $error("lane0 changed high");
  property p_dual_both;
    o_lane0_oe |-> o_lane1_oe;
  endproperty
  a_dual_both: assert property (p_dual_both) else $error("lane0 alone");
  property p_dual_rise;
    $rose(o_lane0_oe) |-> $rose(o_lane1_oe);
  endproperty
  a_dual_rise: assert property (p_dual_rise) else $error("lanes not paired");
  property p_in_frame;
    $rose(o_lane1_oe) |-> !i_spi_cs_n && !i_spi_sck;
  endproperty
  a_in_frame: assert property (p_in_frame) else $error("output outside frame");
  property p_opc_first;
    $rose(o_lane1_oe) |-> rises >= 6'h08;
  endproperty
  a_opc_first: assert property (p_opc_first) else $error("output before opcode");
  property p_busy_dual;
    xbusy |-> !$rose(o_lane0_oe);
  endproperty
  a_busy_dual: assert property (p_busy_dual) else $error("read while busy");
  property p_ro_bits;
    $past(i_reg_rd) && $past(i_reg_addr) == `SFC_REG_STATUS
      |-> o_reg_rdata[31:8] == 24'h0 && !o_reg_rdata[6] && !o_reg_rdata[4];
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("status spare bit set");
  c_dual: cover property ($rose(o_lane0_oe));
  c_busy_stat: cover property (xbusy && $rose(o_lane1_oe));
  c_reg_rd: cover property ($past(i_reg_rd) && o_reg_rdata != 32'h0);
endmodule : sfc_properties
bind sfc_top sfc_properties u_sfc_properties (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_spi_sck(i_spi_sck),
  .i_spi_cs_n(i_spi_cs_n), .o_lane0(o_lane0), .o_lane0_oe(o_lane0_oe),
  .o_lane1(o_lane1), .o_lane1_oe(o_lane1_oe), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata));
`default_nettype wire

// ### sim/sfc_spi_host.sv
// Purpose: SPI host model driving select, clock and lane 0
// Assumes: Half clock period of four core cycles
// Notes:   Lane 0 toggles once released by the host
`timescale 1ns/10ps
`default_nettype none
module sfc_spi_host (
  // Clock
  input  wire logic i_core_clk,
  // Serial link
  input  wire logic i_lane0,
  input  wire logic i_lane1,
  input  wire logic i_oe,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_lane0
);
  logic seen_oe;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_lane0 = 1'b0;
    seen_oe = 1'b0;
  end
  always @(posedge i_core_clk) begin
    if (i_oe) begin
      seen_oe <= 1'b1;
    end
  end
  // Sends ntx bits MSB first, skips nskip clocks, captures nrx clocks
  task automatic xfer(input logic [39:0] tx, input int ntx, input int nskip,
                      input int nrx, input logic dual,
                      output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    seen_oe <= 1'b0;
    for (i = 0; i < ntx + nskip + nrx; i++) begin
      repeat (4) @(posedge i_core_clk);
      o_sck <= 1'b0;
      o_lane0 <= (i < ntx) ? tx[39-i] : ~o_lane0;
      repeat (4) @(posedge i_core_clk);
      o_sck <= 1'b1;
      if (i >= ntx + nskip) begin
        rx = dual ? {rx[29:0], i_lane1, i_lane0} : {rx[30:0], i_lane1};
      end
    end
    repeat (4) @(posedge i_core_clk);
    o_sck <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_lane0 <= ~o_lane0;
    repeat (4) @(posedge i_core_clk);
  endtask : xfer
endmodule : sfc_spi_host
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench of the serial flash command slice
// Assumes: Status write time shortened to 1000 cycles
// Notes:   Undriven lanes toggle so stale values never match
`timescale 1ns/10ps
`default_nettype none
`include "sfc_regs.svh"
module tb;
  typedef struct {
    logic [39:0] tx;
    int          ntx;
    int          nskip;
    int          nrx;
    logic        dual;
    logic        oe;
    logic [31:0] exp;
  } sfc_tb_row_t;
  sfc_tb_row_t rows [9] = '{
    '{{8'h05, 32'h0}, 8, 0, 16, 1'b0, 1'b1, 32'h0000},
    '{{8'h06, 32'h0}, 8, 0, 0, 1'b0, 1'b0, 32'h0},
    '{{8'h05, 32'h0}, 8, 0, 16, 1'b0, 1'b1, 32'h0202},
    '{{8'h03, 24'h000001, 8'h0}, 32, 0, 16, 1'b0, 1'b1, 32'hA4A7},
    '{{8'h0B, 24'h0000FF, 8'h0}, 32, 8, 16, 1'b0, 1'b1, 32'h5AA5},
    '{{8'h3B, 24'h000002, 8'h0}, 32, 8, 8, 1'b1, 1'b1, 32'hA7A6},
    '{{8'h04, 32'h0}, 8, 0, 0, 1'b0, 1'b0, 32'h0},
    '{{8'h05, 32'h0}, 8, 0, 8, 1'b0, 1'b1, 32'h00},
    '{{8'h99, 32'h0}, 8, 0, 8, 1'b0, 1'b0, 32'h0}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sck, cs_n, h_lane0, l1_float = 1'b0;
  logic        lane0_w, lane1_w, o_lane0, o_lane0_oe, o_lane1, o_lane1_oe;
  logic        guard_n = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, rx;
  int          err_total = 0;
  int          num_checks = 0;
  always #4 clk = ~clk;
  always @(posedge clk) l1_float <= ~l1_float;
  assign lane0_w = o_lane0_oe ? o_lane0 : h_lane0;
  assign lane1_w = o_lane1_oe ? o_lane1 : l1_float;
  sfc_top #(.TW_CYC(1000)) u_sfc_top (
    .i_core_clk(clk), .i_rst(rst), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
    .i_lane0(lane0_w), .i_lane1(lane1_w), .o_lane0(o_lane0),
    .o_lane0_oe(o_lane0_oe), .o_lane1(o_lane1), .o_lane1_oe(o_lane1_oe),
    .i_write_guard_n(guard_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  sfc_spi_host u_sfc_spi_host (
    .i_core_clk(clk), .i_lane0(lane0_w), .i_lane1(lane1_w),
    .i_oe(o_lane0_oe | o_lane1_oe), .o_sck(sck), .o_cs_n(cs_n),
    .o_lane0(h_lane0));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd
  task automatic chk_st(input logic [7:0] e);
    logic [31:0] d;
    reg_rd(`SFC_REG_STATUS, d);
    check("status", d, {24'h0, e});
  endtask : chk_st
  task automatic cmd(input logic [7:0] op);
    u_sfc_spi_host.xfer({op, 32'h0}, 8, 0, 0, 1'b0, rx);
  endtask : cmd
  task automatic wsr(input logic [7:0] v);
    u_sfc_spi_host.xfer({8'h01, v, 24'h0}, 16, 0, 0, 1'b0, rx);
  endtask : wsr
  task automatic wait_idle();
    logic [31:0] d;
    int n;
    for (n = 0; n < 2000; n++) begin
      reg_rd(`SFC_REG_STATUS, d);
      if (d[`SFC_ST_BUSY] === 1'b0) break;
    end
    if (n == 2000) begin
      err_total++;
      end_of_test();
    end
  endtask : wait_idle
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_st(8'h00);
    check("oe", {30'h0, o_lane1_oe, o_lane0_oe}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      reg_wr(`SFC_REG_MADDR, (i < 4) ? i : 32'hFF);
      reg_wr(`SFC_REG_MDATA, ((i < 4) ? i : 32'hFF) ^ 32'hA5);
    end
    for (int k = 0; k < 9; k++) begin
      u_sfc_spi_host.xfer(rows[k].tx, rows[k].ntx, rows[k].nskip,
                          rows[k].nrx, rows[k].dual, rx);
      check("oe seen", {31'h0, u_sfc_spi_host.seen_oe}, {31'h0, rows[k].oe});
      if (rows[k].oe) check("rx", rx, rows[k].exp);
      $display("row %0d done", k);
    end
    cmd(8'h06);
    wsr(8'hFF);
    chk_st(8'h03);
    u_sfc_spi_host.xfer({8'h03, 32'h0}, 32, 0, 8, 1'b0, rx);
    check("busy read", {31'h0, u_sfc_spi_host.seen_oe}, 32'h0);
    u_sfc_spi_host.xfer({8'h05, 32'h0}, 8, 0, 8, 1'b0, rx);
    check("busy status", rx, 32'h03);
    wait_idle();
    chk_st(8'hAC);
    $display("test status write done");
    guard_n <= 1'b0;
    cmd(8'h06);
    wsr(8'h00);
    chk_st(8'hAE);
    guard_n <= 1'b1;
    wsr(8'h00);
    wait_idle();
    chk_st(8'h00);
    cmd(8'h06);
    u_sfc_spi_host.xfer({8'h01, 32'h0}, 17, 0, 0, 1'b0, rx);
    chk_st(8'h02);
    $display("test guard done");
    cmd(8'h04);
    cmd(8'h50);
    chk_st(8'h00);
    wsr(8'h2C);
    chk_st(8'h2C);
    cmd(8'h50);
    cmd(8'h04);
    wsr(8'h00);
    chk_st(8'h2C);
    cmd(8'h06);
    reg_wr(`SFC_REG_CTRL, 32'h2);
    chk_st(8'h2C);
    $display("test volatile done");
    reg_wr(`SFC_REG_CTRL, 32'h1);
    reg_rd(`SFC_REG_CTRL, rx);
    check("ctrl", rx, 32'h1);
    cmd(8'h06);
    chk_st(8'h2D);
    u_sfc_spi_host.xfer({8'h05, 32'h0}, 8, 0, 8, 1'b0, rx);
    check("status busy", rx, 32'h2D);
    u_sfc_spi_host.xfer({8'h3B, 32'h0}, 32, 8, 4, 1'b1, rx);
    check("dual busy", {31'h0, u_sfc_spi_host.seen_oe}, 32'h0);
    reg_wr(`SFC_REG_CTRL, 32'h0);
    reg_rd(8'h40, rx);
    check("unmapped", rx, 32'h0);
    $display("test busy done");
    cmd(8'h06);
    chk_st(8'h2E);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_st(8'h00);
    u_sfc_spi_host.xfer({8'h05, 32'h0}, 8, 0, 8, 1'b0, rx);
    check("reset status", rx, 32'h00);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
